// >>> fsbp_pkg.sv
`default_nettype none
package fsbp_pkg;
  // status register bit positions
  localparam int unsigned LOCK_BIT = 7;
  localparam int unsigned QUAD_BIT = 6;
  localparam int unsigned BP_HI = 5;
  localparam int unsigned BP_LO = 2;
  localparam int unsigned WEL_BIT = 1;
  localparam int unsigned WIP_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [5:0] NV_RESET = 6'h00;
  // opcodes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE_A = 8'hd7;
  localparam logic [7:0] OP_SECTOR_ERASE_B = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_FULL_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_INFO_ROW_PROG = 8'h62;
  // memory map
  localparam int unsigned ADDR_W = 18;
  localparam logic [17:0] ARRAY_TOP = 18'h3ffff;
  localparam int unsigned SECTOR_SHIFT = 12;
  localparam int unsigned HALF_BLOCK_SHIFT = 15;
  localparam int unsigned BLOCK_SHIFT = 16;
  // busy durations in cycles
  localparam logic [15:0] T_STATUS_WRITE = 16'h0010;
  localparam logic [15:0] T_PROGRAM = 16'h0020;
  localparam logic [15:0] T_ERASE = 16'h0040;
  typedef enum logic [2:0] {
    FSBP_IDLE = 3'b001,
    FSBP_BUSY = 3'b010,
    FSBP_DONE = 3'b100
  } fsbp_state_t;
endpackage : fsbp_pkg
`default_nettype wire

// >>> fsbp_range_check.sv
`default_nettype none
// decides whether an erase or program target overlaps the protected 64K blocks
module fsbp_range_check (
  input wire logic [3:0] bp_i,
  input wire logic [17:0] lo_i,
  input wire logic [17:0] hi_i,
  output logic hit_o
);
  logic [3:0] prot;
  logic [3:0] touch;
  always_comb begin
    unique case (bp_i)
      4'b0000, 4'b1111: prot = 4'b0000;
      4'b0001: prot = 4'b1000;
      4'b0010: prot = 4'b1100;
      4'b1101: prot = 4'b0011;
      4'b1110: prot = 4'b0001;
      default: prot = 4'b1111;
    endcase
  end
  for (genvar b = 0; b < 4; b++) begin : g_blk
    assign touch[b] = (lo_i[17:16] <= 2'(b)) && (hi_i[17:16] >= 2'(b));
  end
  assign hit_o = |(prot & touch);
endmodule : fsbp_range_check
`default_nettype wire

// >>> fsbp_status_protect.sv
`default_nettype none
module fsbp_status_protect (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_op_i,
  input wire logic [17:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic wp_pin_n_i,
  output logic [7:0] status_o,
  output logic op_start_o,
  output logic op_reject_o,
  output logic op_done_o,
  output logic quad_pins_o,
  output logic wp_func_o,
  output logic pause_func_o
);
  // synchronised protect pin
  logic wp_meta_n;
  logic wp_sync_n;

  // status bits
  logic [5:0] nv_bits;
  logic write_enable_latch;
  logic write_in_progress;

  // sequencer
  fsbp_pkg::fsbp_state_t state;
  logic [15:0] busy_cnt;
  logic [7:0] pend_op;
  logic [7:0] pend_data;
  logic [15:0] dur;

  // decode of the instruction on the bus
  logic [17:0] lo_addr;
  logic [17:0] hi_addr;
  logic in_prot;
  logic is_gated;
  logic is_prog_erase;
  logic is_chip_erase;
  logic is_status_write;
  logic is_set_latch;
  logic is_clear_latch;

  // refusal reasons and outcome
  logic nv_locked;
  logic refuse_latch;
  logic refuse_busy;
  logic refuse_lock;
  logic refuse_chip;
  logic refuse_area;
  logic accept;
  logic latch_cmd_ok;

  fsbp_range_check u_range (
    .bp_i(nv_bits[3:0]),
    .lo_i(lo_addr),
    .hi_i(hi_addr),
    .hit_o(in_prot)
  );

  // protect pin from outside the clock domain, first stage
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wp_meta_n <= 1'b1;
    end else begin
      wp_meta_n <= wp_pin_n_i;
    end
  end

  // second stage, the only reader of the first
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wp_sync_n <= 1'b1;
    end else begin
      wp_sync_n <= wp_meta_n;
    end
  end

  always_comb begin
    is_prog_erase = 1'b1;
    is_chip_erase = 1'b0;
    lo_addr = cmd_addr_i;
    hi_addr = cmd_addr_i;
    unique case (cmd_op_i)
      fsbp_pkg::OP_PAGE_PROG, fsbp_pkg::OP_QUAD_PROG: begin
      end
      fsbp_pkg::OP_SECTOR_ERASE_A, fsbp_pkg::OP_SECTOR_ERASE_B: begin
        lo_addr = {cmd_addr_i[17:fsbp_pkg::SECTOR_SHIFT], 12'h000};
        hi_addr = {cmd_addr_i[17:fsbp_pkg::SECTOR_SHIFT], 12'hfff};
      end
      fsbp_pkg::OP_HALF_BLOCK_ERASE: begin
        lo_addr = {cmd_addr_i[17:fsbp_pkg::HALF_BLOCK_SHIFT], 15'h0000};
        hi_addr = {cmd_addr_i[17:fsbp_pkg::HALF_BLOCK_SHIFT], 15'h7fff};
      end
      fsbp_pkg::OP_FULL_BLOCK_ERASE: begin
        lo_addr = {cmd_addr_i[17:fsbp_pkg::BLOCK_SHIFT], 16'h0000};
        hi_addr = {cmd_addr_i[17:fsbp_pkg::BLOCK_SHIFT], 16'hffff};
      end
      fsbp_pkg::OP_CHIP_ERASE_A, fsbp_pkg::OP_CHIP_ERASE_B: begin
        is_chip_erase = 1'b1;
        lo_addr = 18'h00000;
        hi_addr = fsbp_pkg::ARRAY_TOP;
      end
      default: is_prog_erase = 1'b0;
    endcase
  end

  assign is_status_write = (cmd_op_i == fsbp_pkg::OP_STATUS_WRITE);
  assign is_set_latch = (cmd_op_i == fsbp_pkg::OP_SET_LATCH);
  assign is_clear_latch = (cmd_op_i == fsbp_pkg::OP_CLR_LATCH);
  assign is_gated = is_prog_erase || is_status_write
                    || (cmd_op_i == fsbp_pkg::OP_INFO_ROW_PROG);
  assign nv_locked = nv_bits[5] && !wp_sync_n;

  // every reason a gated instruction is ignored, kept apart for clarity
  assign refuse_latch = !write_enable_latch;
  assign refuse_busy = write_in_progress || (state != fsbp_pkg::FSBP_IDLE);
  assign refuse_lock = is_status_write && nv_locked;
  assign refuse_chip = is_chip_erase && (nv_bits[3:0] != 4'h0);
  assign refuse_area = is_prog_erase && !is_chip_erase && in_prot;

  assign accept = cmd_valid_i && is_gated
                  && !(refuse_latch || refuse_busy || refuse_lock || refuse_chip || refuse_area);

  // set and clear of the latch are ignored while an operation runs
  assign latch_cmd_ok = cmd_valid_i && !write_in_progress && (state == fsbp_pkg::FSBP_IDLE);

  // busy time of the instruction on the bus
  always_comb begin
    dur = fsbp_pkg::T_PROGRAM;
    unique case (cmd_op_i)
      fsbp_pkg::OP_STATUS_WRITE: begin
        dur = fsbp_pkg::T_STATUS_WRITE;
      end
      fsbp_pkg::OP_SECTOR_ERASE_A, fsbp_pkg::OP_SECTOR_ERASE_B, fsbp_pkg::OP_HALF_BLOCK_ERASE,
      fsbp_pkg::OP_FULL_BLOCK_ERASE, fsbp_pkg::OP_CHIP_ERASE_A, fsbp_pkg::OP_CHIP_ERASE_B: begin
        dur = fsbp_pkg::T_ERASE;
      end
      default: begin
        dur = fsbp_pkg::T_PROGRAM;
      end
    endcase
  end

  // operation sequencer: busy for a fixed time then completes
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state <= fsbp_pkg::FSBP_IDLE;
    end else begin
      unique case (state)
        fsbp_pkg::FSBP_IDLE: begin
          if (accept) begin
            state <= fsbp_pkg::FSBP_BUSY;
          end
        end
        fsbp_pkg::FSBP_BUSY: begin
          if (busy_cnt == 16'h0001) begin
            state <= fsbp_pkg::FSBP_DONE;
          end
        end
        fsbp_pkg::FSBP_DONE: begin
          state <= fsbp_pkg::FSBP_IDLE;
        end
        default: begin
          state <= fsbp_pkg::FSBP_IDLE;
        end
      endcase
    end
  end

  // remaining busy time of the running operation
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      busy_cnt <= 16'h0000;
    end else if (state == fsbp_pkg::FSBP_IDLE && accept) begin
      busy_cnt <= dur;
    end else if (state == fsbp_pkg::FSBP_BUSY) begin
      busy_cnt <= busy_cnt - 16'h0001;
    end
  end

  // opcode and data of the accepted operation, applied at completion
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pend_op <= 8'h00;
      pend_data <= 8'h00;
    end else if (state == fsbp_pkg::FSBP_IDLE && accept) begin
      pend_op <= cmd_op_i;
      pend_data <= cmd_data_i;
    end
  end

  // busy flag follows the sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      write_in_progress <= 1'b0;
    end else begin
      write_in_progress <= (state == fsbp_pkg::FSBP_IDLE) ? accept : (state == fsbp_pkg::FSBP_BUSY);
    end
  end

  // non-volatile bits: only status write touches them
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      nv_bits <= fsbp_pkg::NV_RESET;
    end else if (state == fsbp_pkg::FSBP_DONE && pend_op == fsbp_pkg::OP_STATUS_WRITE) begin
      nv_bits <= pend_data[fsbp_pkg::LOCK_BIT:fsbp_pkg::BP_LO];
    end
  end

  // write enable latch; completion clear wins over a set
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      write_enable_latch <= 1'b0;
    end else if (state == fsbp_pkg::FSBP_DONE) begin
      write_enable_latch <= 1'b0;
    end else if (latch_cmd_ok && is_set_latch) begin
      write_enable_latch <= 1'b1;
    end else if (latch_cmd_ok && is_clear_latch) begin
      write_enable_latch <= 1'b0;
    end
  end

  // registered copy of the status byte
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      status_o <= fsbp_pkg::STATUS_RESET;
    end else begin
      status_o <= {nv_bits, write_enable_latch, write_in_progress};
    end
  end

  // pulse: gated instruction taken
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      op_start_o <= 1'b0;
    end else begin
      op_start_o <= (state == fsbp_pkg::FSBP_IDLE) && accept;
    end
  end

  // pulse: gated instruction ignored
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      op_reject_o <= 1'b0;
    end else begin
      op_reject_o <= cmd_valid_i && is_gated && !((state == fsbp_pkg::FSBP_IDLE) && accept);
    end
  end

  // pulse: operation completed
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      op_done_o <= 1'b0;
    end else begin
      op_done_o <= (state == fsbp_pkg::FSBP_DONE);
    end
  end

  // pin roles follow the quad bit
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      quad_pins_o <= 1'b0;
    end else begin
      quad_pins_o <= nv_bits[4];
    end
  end

  // protect pin keeps its role while quad is off
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      wp_func_o <= 1'b1;
    end else begin
      wp_func_o <= !nv_bits[4];
    end
  end

  // pause pin keeps its role while quad is off
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pause_func_o <= 1'b1;
    end else begin
      pause_func_o <= !nv_bits[4];
    end
  end
endmodule : fsbp_status_protect
`default_nettype wire

// >>> fsbp_props.sv
`default_nettype none
module fsbp_props (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_op_i,
  input wire logic wp_pin_n_i,
  input wire logic [7:0] status_o,
  input wire logic op_start_o,
  input wire logic op_reject_o,
  input wire logic op_done_o,
  input wire logic quad_pins_o,
  input wire logic wp_func_o,
  input wire logic pause_func_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic gated;
  assign gated = cmd_valid_i && (cmd_op_i inside {8'h02, 8'h32, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h01, 8'h62});
  chk_latch_gate: assert property (gated ##1 !status_o[1] |-> op_reject_o)
    else $error("gated op not refused without latch");
  chk_chip_bp: assert property (cmd_valid_i && cmd_op_i inside {8'hc7, 8'h60} ##1 status_o[5:2] != 4'h0 |-> op_reject_o)
    else $error("chip erase not refused");
  chk_lock_pin: assert property (cmd_valid_i && cmd_op_i == 8'h01 && !wp_pin_n_i && !$past(wp_pin_n_i, 1) && !$past(wp_pin_n_i, 2) && !$past(wp_pin_n_i, 3) ##1 status_o[7] |-> op_reject_o)
    else $error("locked status write not refused");
  chk_start_busy: assert property (op_start_o |=> status_o[0])
    else $error("busy not shown after start");
  chk_done_idle: assert property (op_done_o |-> ##[1:2] !status_o[0])
    else $error("busy stuck after done");
  chk_done_latch: assert property (op_done_o |-> ##[1:2] !status_o[1])
    else $error("latch not cleared at done");
  chk_set_write_latch_cmd_set: assert property (cmd_valid_i && cmd_op_i == 8'h06 ##1 !status_o[0] && !cmd_valid_i |=> status_o[1])
    else $error("latch not set");
  chk_clear_write_latch_cmd_clr: assert property (cmd_valid_i && cmd_op_i == 8'h04 ##1 !status_o[0] && !cmd_valid_i |=> !status_o[1])
    else $error("latch not cleared");
  chk_quad_track: assert property (quad_pins_o != status_o[6] |=> quad_pins_o == status_o[6])
    else $error("quad pins do not follow quad bit");
  chk_pin_roles: assert property (wp_func_o == !quad_pins_o && pause_func_o == !quad_pins_o)
    else $error("pin roles disagree");
  cover property (op_start_o);
  cover property (op_reject_o);
  cover property (op_done_o ##2 status_o[7]);
endmodule : fsbp_props
bind fsbp_status_protect fsbp_props u_props (.sys_clk_i, .nrst_i, .cmd_valid_i, .cmd_op_i, .wp_pin_n_i, .status_o,
  .op_start_o, .op_reject_o, .op_done_o, .quad_pins_o, .wp_func_o, .pause_func_o);
`default_nettype wire

// >>> fsbp_host_model.sv
`default_nettype none
module fsbp_host_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] status_i,
  input wire logic op_start_i,
  input wire logic op_reject_i,
  input wire logic op_done_i,
  output logic cmd_valid_o = 1'b0,
  output logic [7:0] cmd_op_o = 8'h00,
  output logic [17:0] cmd_addr_o = 18'h00000,
  output logic [7:0] cmd_data_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic pulse(input logic [7:0] o, input logic [17:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o = o;
    cmd_addr_o = a;
    cmd_data_o = d;
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b0;
    // released lines carry no stale value
    cmd_op_o = ~o;
    cmd_addr_o = ~a;
    cmd_data_o = ~d;
  endtask : pulse
  task automatic issue(input logic [7:0] o, input logic [17:0] a, input logic [7:0] d, input logic w,
    output logic [1:0] res);
    int n;
    n = 0;
    while (status_i[0] !== 1'b0 && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (w) begin
      pulse(fsbp_pkg::OP_SET_LATCH, a, d);
    end
    pulse(o, a, d);
    res = {op_start_i, op_reject_i};
    n = 0;
    while (res[1] && op_done_i !== 1'b1 && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    repeat (2) @(negedge sys_clk_i);
  endtask : issue
endmodule : fsbp_host_model
`default_nettype wire

// >>> fsbp_status_protect_bench.sv
`default_nettype none
module fsbp_status_protect_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wp_pin_n_i = 1'b1;
  logic cmd_valid_i, op_start_o, op_reject_o, op_done_o, quad_pins_o, wp_func_o, pause_func_o;
  logic [7:0] cmd_op_i, cmd_data_i, status_o;
  logic [17:0] cmd_addr_i;
  logic [1:0] r;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] gop [10] = '{8'h02, 8'h32, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h01, 8'h62};
  // bp code, opcode, target, refused
  logic [30:0] tbl [15] = '{{4'h0, 8'hc7, 18'h00000, 1'b0}, {4'h1, 8'h20, 18'h30000, 1'b1},
    {4'h1, 8'h02, 18'h2ffff, 1'b0}, {4'h1, 8'h60, 18'h00000, 1'b1}, {4'h2, 8'hd7, 18'h20000, 1'b1},
    {4'h2, 8'h52, 18'h18000, 1'b0}, {4'h3, 8'hd8, 18'h00000, 1'b1}, {4'h8, 8'h62, 18'h00000, 1'b0},
    {4'hc, 8'h32, 18'h10000, 1'b1}, {4'hd, 8'h20, 18'h1f000, 1'b1}, {4'hd, 8'hd8, 18'h20000, 1'b0},
    {4'he, 8'h20, 18'h0f000, 1'b1}, {4'he, 8'h20, 18'h10000, 1'b0}, {4'hf, 8'h52, 18'h38000, 1'b0},
    {4'h7, 8'h02, 18'h3ffff, 1'b1}};
  always #5 sys_clk_i = ~sys_clk_i;
  fsbp_status_protect dut (.sys_clk_i, .nrst_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i, .cmd_data_i, .wp_pin_n_i,
    .status_o, .op_start_o, .op_reject_o, .op_done_o, .quad_pins_o, .wp_func_o, .pause_func_o);
  fsbp_host_model host (.sys_clk_i, .status_i(status_o), .op_start_i(op_start_o), .op_reject_i(op_reject_o),
    .op_done_i(op_done_o), .cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i), .cmd_addr_o(cmd_addr_i),
    .cmd_data_o(cmd_data_i));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic op(input logic [7:0] o, input logic [17:0] a, input logic [7:0] d, input logic w, input logic [1:0] e);
    host.issue(o, a, d, w, r);
    chk("answer", {6'h00, e}, {6'h00, r});
  endtask : op
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    chk("status", 8'h00, status_o);
    chk("roles", 8'h03, {5'h00, quad_pins_o, wp_func_o, pause_func_o});
    foreach (gop[i]) op(gop[i], 18'h00000, 8'h00, 1'b0, 2'b01);
    op(8'h06, 18'h00000, 8'h00, 1'b0, 2'b00);
    chk("status", 8'h02, status_o);
    op(8'h04, 18'h00000, 8'h00, 1'b0, 2'b00);
    chk("status", 8'h00, status_o);
    op(8'h01, 18'h00000, 8'hff, 1'b1, 2'b10);
    chk("status", 8'hfc, status_o);
    chk("roles", 8'h04, {5'h00, quad_pins_o, wp_func_o, pause_func_o});
    wp_pin_n_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    op(8'h01, 18'h00000, 8'h00, 1'b1, 2'b01);
    chk("nv bits", 8'hfc, {status_o[7:2], 2'b00});
    wp_pin_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    op(8'h01, 18'h00000, 8'h00, 1'b1, 2'b10);
    chk("status", 8'h00, status_o);
    foreach (tbl[i]) begin
      op(8'h01, 18'h00000, {2'b00, tbl[i][30:27], 2'b00}, 1'b1, 2'b10);
      op(tbl[i][26:19], tbl[i][18:1], 8'h00, 1'b1, {!tbl[i][0], tbl[i][0]});
    end
    stop_test();
  end
endmodule : fsbp_status_protect_bench
`default_nettype wire
